// file: hw/dcq_pkg.sv
// constants for the dma crc, service level and debug register block
package dcq_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] DCQ_IDX_CONTROL = 8'h00;
  localparam logic [7:0] DCQ_IDX_SETUP = 8'h02;
  localparam logic [7:0] DCQ_IDX_INPUT = 8'h04;
  localparam logic [7:0] DCQ_IDX_RESULT = 8'h08;
  localparam logic [7:0] DCQ_IDX_STATUS = 8'h0c;
  localparam logic [7:0] DCQ_IDX_DEBUG = 8'h0d;
  localparam logic [7:0] DCQ_IDX_SERVICE = 8'h0e;
  localparam logic [7:0] DCQ_IDX_TRIGGER = 8'h10;
  // reset values
  localparam logic [31:0] DCQ_RST_WORD = 32'h0000_0000;
  localparam logic [5:0] DCQ_RST_SERVICE = 6'h15;
  // field positions
  localparam int DCQ_CTL_SWRST = 0;
  localparam int DCQ_CTL_DMAEN = 1;
  localparam int DCQ_CTL_CRCEN = 2;
  localparam int DCQ_SETUP_SRC_LSB = 8;
  localparam int DCQ_SETUP_POLY_LSB = 2;
  localparam int DCQ_SETUP_WIDTH_LSB = 0;
  localparam int DCQ_STAT_BUSY = 0;
  // feed select codes
  localparam logic [5:0] DCQ_SRC_NONE = 6'h00;
  localparam logic [5:0] DCQ_SRC_IO = 6'h01;
  localparam logic [5:0] DCQ_SRC_CHAN_FIRST = 6'h20;
  // polynomial codes and values
  localparam logic [1:0] DCQ_POLY_CRC16 = 2'h0;
  localparam logic [1:0] DCQ_POLY_CRC32 = 2'h1;
  localparam logic [31:0] DCQ_GEN_CRC32 = 32'h04c1_1db7;
  localparam logic [15:0] DCQ_GEN_CRC16 = 16'h1021;
  // access width codes
  localparam logic [1:0] DCQ_WIDTH_BYTE = 2'h0;
  localparam logic [1:0] DCQ_WIDTH_HALF = 2'h1;
  localparam logic [1:0] DCQ_WIDTH_WORD = 2'h2;
  // bus
  localparam logic [1:0] DCQ_HTRANS_NONSEQ = 2'h2;
endpackage : dcq_pkg

// file: hw/dcq_crc_regs.sv
// crc unit, service levels, debug halt and soft trigger registers on ahb-lite
//
// Notes on behaviour
// - a write to crc_input_word starts a checksum update over the low bytes given by the access width
// - one byte folded per clock; latency equals bytes of the access width
// - with the 16-bit polynomial the upper checksum half reads zero
// - checksum is valid once crc_in_progress is clear; software reads then
// - 32-bit result is presented bit-reversed across the whole word
// - selecting a new feed clears zero_result_flag
// - zero_result_flag sets when a computation ends with zero checksum
// - bus feed: every input word write sets crc_in_progress
// - bus feed: writing one clears crc_in_progress, writing zero is ignored
// - channel feed: busy follows the selected channel enable
// - channel feed: software writes of one to busy are ignored
// - run_while_halted zero halts the controller during a debug halt
// - run_while_halted survives the controller software reset
// - transfer_service_level two bits give four memory priority levels
// - fetch and writeback service levels use the same four-level coding
// - one trigger bit per channel in 5:0, upper bits read zero
// - polynomial code 0 is 16-bit ccitt, code 1 is 32-bit ethernet
// - access width codes byte, half-word, word for bus feed writes
// - feed select is locked while busy unless the crc unit is disabled
module dcq_crc_regs
  import dcq_pkg::*;
#(
  parameter int NUM_CHAN = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic [NUM_CHAN-1:0] i_chan_enable,
  input wire logic [NUM_CHAN-1:0] i_chan_pending,
  input wire logic i_dma_crc_valid,
  input wire logic [31:0] i_dma_crc_data,
  output logic o_dma_crc_ready,
  input wire logic i_cpu_debug_halted,
  output logic o_dma_halted,
  output logic o_dma_enable,
  output logic [1:0] o_transfer_service_level,
  output logic [1:0] o_fetch_service_level,
  output logic [1:0] o_writeback_service_level,
  output logic [NUM_CHAN-1:0] o_per_channel_trigger_bit
);

  if (NUM_CHAN < 1 || NUM_CHAN > 6) begin : g_chan_check
    $error("NUM_CHAN must be 1 to 6");
  end

  function automatic logic [31:0] crc_byte(input logic [31:0] s, input logic [7:0] d,
                                           input logic is32);
    logic [31:0] c;
    logic fb;
    c = s;
    for (int i = 7; i >= 0; i--) begin
      if (is32) begin
        fb = c[31] ^ d[i];
        c = {c[30:0], 1'b0} ^ (fb ? DCQ_GEN_CRC32 : 32'h0000_0000);
      end else begin
        fb = c[15] ^ d[i];
        c = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, DCQ_GEN_CRC16} : 32'h0000_0000);
      end
    end
    return c;
  endfunction : crc_byte

  function automatic logic [31:0] bit_rev(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction : bit_rev

  // bus pipeline state
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  // registers
  logic dma_en_reg;
  logic crc_en_reg;
  logic [5:0] src_reg;
  logic [1:0] poly_reg;
  logic [1:0] width_reg;
  logic [31:0] in_word_reg;
  logic [31:0] crc_state_reg;
  logic [31:0] data_sh_reg;
  logic [2:0] bytes_left_reg;
  logic busy_reg;
  logic zero_reg;
  logic run_halt_reg;
  logic halted_reg;
  logic [5:0] qos_reg;
  logic [NUM_CHAN-1:0] trig_reg;
  logic dma_ready_reg;

  logic acc;
  logic wr_go;
  logic [7:0] a_idx;
  logic is32;
  logic is_chan_src;
  logic [4:0] chan_idx;
  logic chan_sel_en;
  logic start_io;
  logic dma_take;
  logic step;
  logic last_step;
  logic [31:0] crc_step_val;
  logic [2:0] beat_bytes;
  logic [2:0] bytes_left_next;
  logic swrst;
  logic rst_all;
  logic [31:0] rd_mux;

  assign acc = i_hsel && (i_htrans == DCQ_HTRANS_NONSEQ) && i_hready;
  assign wr_go = dp_valid_reg && dp_write_reg && hreadyout_reg;
  assign is32 = (poly_reg == DCQ_POLY_CRC32);
  assign is_chan_src = (src_reg[5:5] == DCQ_SRC_CHAN_FIRST[5:5]);
  assign chan_idx = src_reg[4:0];

  // an unmapped index in address bits 7:2 reads zero
  assign a_idx = {2'b00, i_haddr[7:2]};

  always_comb begin
    chan_sel_en = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (chan_idx == i[4:0]) begin
        chan_sel_en = i_chan_enable[i];
      end
    end
  end

  always_comb begin
    case (width_reg)
      DCQ_WIDTH_BYTE: beat_bytes = 3'd1;
      DCQ_WIDTH_HALF: beat_bytes = 3'd2;
      DCQ_WIDTH_WORD: beat_bytes = 3'd4;
      default: beat_bytes = 3'd4;
    endcase
  end

  // bus feed start on input word write
  assign start_io = wr_go && (dp_addr_reg == DCQ_IDX_INPUT) && (src_reg == DCQ_SRC_IO)
                    && crc_en_reg;
  assign dma_take = i_dma_crc_valid && dma_ready_reg && is_chan_src && crc_en_reg;
  // engine freezes during a debug halt
  assign step = (bytes_left_reg != 3'd0) && !halted_reg;
  assign last_step = step && (bytes_left_reg == 3'd1);
  assign crc_step_val = crc_byte(crc_state_reg, data_sh_reg[7:0], is32);

  always_comb begin
    bytes_left_next = bytes_left_reg;
    if (step) begin
      bytes_left_next = bytes_left_reg - 3'd1;
    end
    if (start_io || dma_take) begin
      bytes_left_next = beat_bytes;
    end
  end

  // software reset only with both units disabled; otherwise ignored
  assign swrst = wr_go && (dp_addr_reg == DCQ_IDX_CONTROL) && i_hwdata[DCQ_CTL_SWRST]
                 && !dma_en_reg && !crc_en_reg;
  assign rst_all = i_srst || swrst;

  // bus handshake: reads take one wait state so a preceding write is visible
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
    end else begin
      if (i_hready) begin
        dp_valid_reg <= acc;
        dp_write_reg <= i_hwrite;
        dp_addr_reg <= a_idx;
      end
      if (acc && !i_hwrite) begin
        hreadyout_reg <= 1'b0;
      end else if (acc && a_idx == DCQ_IDX_INPUT && bytes_left_next != 3'd0) begin
        // input write waits until the engine drains the previous beat
        hreadyout_reg <= 1'b0;
      end else if (dp_valid_reg && !hreadyout_reg && dp_write_reg) begin
        hreadyout_reg <= (bytes_left_next == 3'd0);
      end else begin
        hreadyout_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    case (dp_addr_reg)
      DCQ_IDX_CONTROL: rd_mux = {29'h0, crc_en_reg, dma_en_reg, 1'b0};
      DCQ_IDX_SETUP: rd_mux = {18'h0, src_reg, 4'h0, poly_reg, width_reg};
      DCQ_IDX_INPUT: rd_mux = in_word_reg;
      // reversed word for 32-bit, upper half zero for 16-bit
      DCQ_IDX_RESULT: rd_mux = is32 ? bit_rev(crc_state_reg) : {16'h0, crc_state_reg[15:0]};
      DCQ_IDX_STATUS: rd_mux = {30'h0, zero_reg, busy_reg};
      DCQ_IDX_DEBUG: rd_mux = {31'h0, run_halt_reg};
      DCQ_IDX_SERVICE: rd_mux = {26'h0, qos_reg};
      DCQ_IDX_TRIGGER: rd_mux = {{(32 - NUM_CHAN){1'b0}}, trig_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      hrdata_reg <= DCQ_RST_WORD;
    end else if (dp_valid_reg && !dp_write_reg && !hreadyout_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      dma_en_reg <= 1'b0;
      crc_en_reg <= 1'b0;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_CONTROL) begin
      dma_en_reg <= i_hwdata[DCQ_CTL_DMAEN];
      // disabling the crc unit is refused while busy
      if (i_hwdata[DCQ_CTL_CRCEN] || !busy_reg) begin
        crc_en_reg <= i_hwdata[DCQ_CTL_CRCEN];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      src_reg <= DCQ_SRC_NONE;
      poly_reg <= DCQ_POLY_CRC16;
      width_reg <= DCQ_WIDTH_BYTE;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_SETUP) begin
      poly_reg <= i_hwdata[DCQ_SETUP_POLY_LSB +: 2];
      width_reg <= i_hwdata[DCQ_SETUP_WIDTH_LSB +: 2];
      // feed select locked during a computation
      if (!(busy_reg && crc_en_reg)) begin
        src_reg <= i_hwdata[DCQ_SETUP_SRC_LSB +: 6];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      in_word_reg <= DCQ_RST_WORD;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_INPUT) begin
      in_word_reg <= i_hwdata;
    end else if (dma_take) begin
      in_word_reg <= i_dma_crc_data;
    end
  end

  // fold low byte first, shift right one byte per step
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      data_sh_reg <= DCQ_RST_WORD;
      bytes_left_reg <= 3'd0;
      dma_ready_reg <= 1'b0;
    end else begin
      bytes_left_reg <= bytes_left_next;
      dma_ready_reg <= (bytes_left_next == 3'd0);
      if (start_io) begin
        data_sh_reg <= i_hwdata;
      end else if (dma_take) begin
        data_sh_reg <= i_dma_crc_data;
      end else if (step) begin
        data_sh_reg <= {8'h00, data_sh_reg[31:8]};
      end
    end
  end

  // software seed write stores the internal form so a 32-bit seed reads back unchanged and a 16-bit seed keeps its low half
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      crc_state_reg <= DCQ_RST_WORD;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_RESULT) begin
      crc_state_reg <= is32 ? bit_rev(i_hwdata) : {16'h0, i_hwdata[15:0]};
    end else if (step) begin
      crc_state_reg <= crc_step_val;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      busy_reg <= 1'b0;
    end else if (is_chan_src) begin
      // channel feed mirrors the channel enable
      // software writes have no effect here
      busy_reg <= chan_sel_en;
    end else if (src_reg == DCQ_SRC_IO) begin
      // input write sets; set wins over a same-cycle clear
      if (wr_go && dp_addr_reg == DCQ_IDX_INPUT) begin
        busy_reg <= 1'b1;
      // write of one clears, zero ignored
      end else if (wr_go && dp_addr_reg == DCQ_IDX_STATUS && i_hwdata[DCQ_STAT_BUSY]) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      zero_reg <= 1'b0;
    // completion with zero checksum, wins over clear
    end else if (last_step && (is32 ? crc_step_val == 32'h0 : crc_step_val[15:0] == 16'h0)) begin
      zero_reg <= 1'b1;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_SETUP && !(busy_reg && crc_en_reg)) begin
      zero_reg <= 1'b0;
    end
  end

  // only the system reset clears run_while_halted
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      run_halt_reg <= 1'b0;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_DEBUG) begin
      run_halt_reg <= i_hwdata[0];
    end
  end

  // halt only while the debugger holds the cpu and running is not allowed
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      halted_reg <= 1'b0;
    end else begin
      halted_reg <= i_cpu_debug_halted && !run_halt_reg;
    end
  end

  // service levels: data 5:4, fetch 3:2, writeback 1:0
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      qos_reg <= DCQ_RST_SERVICE;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_SERVICE) begin
      qos_reg <= i_hwdata[5:0];
    end
  end

  // per channel trigger; a write beats a same-cycle pending clear
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      trig_reg <= '0;
    end else if (wr_go && dp_addr_reg == DCQ_IDX_TRIGGER) begin
      trig_reg <= i_hwdata[NUM_CHAN-1:0];
    end else begin
      trig_reg <= trig_reg & ~i_chan_pending;
    end
  end

  assign o_hreadyout = hreadyout_reg;
  assign o_hrdata = hrdata_reg;
  assign o_hresp = 1'b0;
  assign o_dma_crc_ready = dma_ready_reg;
  assign o_dma_halted = halted_reg;
  assign o_dma_enable = dma_en_reg;
  assign o_transfer_service_level = qos_reg[5:4];
  assign o_fetch_service_level = qos_reg[3:2];
  assign o_writeback_service_level = qos_reg[1:0];
  assign o_per_channel_trigger_bit = trig_reg;

endmodule : dcq_crc_regs

// file: testbench/dcq_crc_regs_checker.sv
// assertions on the ports of the crc, service level and debug register block
module dcq_crc_regs_checker
  import dcq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_dma_crc_ready,
  input wire logic i_cpu_debug_halted,
  input wire logic o_dma_halted,
  input wire logic o_dma_enable,
  input wire logic [1:0] o_transfer_service_level,
  input wire logic [1:0] o_fetch_service_level,
  input wire logic [1:0] o_writeback_service_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  logic [7:0] idx;
  logic taken;
  assign idx = {2'b00, i_haddr[7:2]};
  assign taken = i_hsel && i_htrans == DCQ_HTRANS_NONSEQ && i_hready;
  sequence rd_taken;
    taken && !i_hwrite;
  endsequence
  sequence rd_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  a_read_one_wait: assert property (rd_taken |=> rd_answer)
    else $error("read wait state wrong");
  // only the input word may stall, the engine being busy
  a_write_no_wait: assert property (taken && i_hwrite && idx != DCQ_IDX_INPUT |=> o_hreadyout)
    else $error("write stalled");
  a_input_stall_max: assert property ($fell(o_hreadyout) |-> ##[1:5] o_hreadyout)
    else $error("bus stall too long");
  a_engine_bytes: assert property ($fell(o_dma_crc_ready) |-> ##[1:5] o_dma_crc_ready)
    else $error("engine busy too long");
  a_halt_needs_debug: assert property (!$past(i_cpu_debug_halted) |-> !o_dma_halted)
    else $error("halted without debugger");
  a_reset_levels: assert property ($fell(i_srst) |-> o_transfer_service_level == 2'h1
      && o_fetch_service_level == 2'h1 && o_writeback_service_level == 2'h1 && !o_dma_enable)
    else $error("reset levels wrong");
  a_trig_upper_zero: assert property (rd_taken ##0 idx == DCQ_IDX_TRIGGER |=> ##1
      o_hrdata[31:6] == 26'h0)
    else $error("trigger reserved bits set");
  a_debug_upper_zero: assert property (rd_taken ##0 idx == DCQ_IDX_DEBUG |=> ##1
      o_hrdata[31:1] == 31'h0)
    else $error("debug reserved bits set");
  a_status_upper_zero: assert property (rd_taken ##0 idx == DCQ_IDX_STATUS |=> ##1
      o_hrdata[31:2] == 30'h0)
    else $error("status reserved bits set");
  a_levels_readback: assert property (rd_taken ##0 idx == DCQ_IDX_SERVICE |=> ##1
      o_hrdata == {26'h0, o_transfer_service_level, o_fetch_service_level,
      o_writeback_service_level})
    else $error("service levels differ from readback");
endmodule : dcq_crc_regs_checker

bind dcq_crc_regs dcq_crc_regs_checker dcq_crc_regs_checker_inst (.i_clk_sys(i_clk_sys),
  .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
  .o_dma_crc_ready(o_dma_crc_ready), .i_cpu_debug_halted(i_cpu_debug_halted),
  .o_dma_halted(o_dma_halted), .o_dma_enable(o_dma_enable),
  .o_transfer_service_level(o_transfer_service_level),
  .o_fetch_service_level(o_fetch_service_level),
  .o_writeback_service_level(o_writeback_service_level));

// file: testbench/dcq_chan_feed.sv
// behavioural dma channel that feeds words into the crc unit
module dcq_chan_feed (
  input wire logic i_clk_sys,
  input wire logic i_dma_crc_ready,
  output logic [5:0] o_chan_enable,
  output logic o_dma_crc_valid,
  output logic [31:0] o_dma_crc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_chan_enable = 6'h00;
    o_dma_crc_valid = 1'b0;
    o_dma_crc_data = 32'h0;
  end
  task automatic set_en(input int ch, input logic en);
    @(posedge i_clk_sys);
    o_chan_enable[ch] <= en;
  endtask : set_en
  // slow or prompt offer, held until ready is sampled high
  task automatic push(input logic [31:0] w, input int stall);
    repeat (stall) @(posedge i_clk_sys);
    o_dma_crc_valid <= 1'b1;
    o_dma_crc_data <= w;
    do @(posedge i_clk_sys); while (i_dma_crc_ready !== 1'b1);
    o_dma_crc_valid <= 1'b0;
    // released data never shows the stale word
    o_dma_crc_data <= ~w;
  endtask : push
endmodule : dcq_chan_feed

// file: testbench/tb.sv
// self-checking bench for the crc, service level and debug register block
module tb
  import dcq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_srst, i_hsel, i_hwrite, i_cpu_debug_halted, i_hready, o_hreadyout;
  logic o_hresp, i_dma_crc_valid, o_dma_crc_ready, o_dma_halted, o_dma_enable;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, i_dma_crc_data, rnd, v, e;
  logic [1:0] i_htrans, o_transfer_service_level, o_fetch_service_level;
  logic [1:0] o_writeback_service_level;
  logic [2:0] i_hsize;
  logic [5:0] i_chan_enable, i_chan_pending, o_per_channel_trigger_bit;
  int error_cnt, num_checks;
  assign i_hready = o_hreadyout;
  dcq_crc_regs dcq_crc_regs_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hresp(o_hresp), .i_chan_enable(i_chan_enable), .i_chan_pending(i_chan_pending),
    .i_dma_crc_valid(i_dma_crc_valid), .i_dma_crc_data(i_dma_crc_data),
    .o_dma_crc_ready(o_dma_crc_ready), .i_cpu_debug_halted(i_cpu_debug_halted),
    .o_dma_halted(o_dma_halted), .o_dma_enable(o_dma_enable),
    .o_transfer_service_level(o_transfer_service_level),
    .o_fetch_service_level(o_fetch_service_level),
    .o_writeback_service_level(o_writeback_service_level),
    .o_per_channel_trigger_bit(o_per_channel_trigger_bit));
  dcq_chan_feed dcq_chan_feed_inst (.i_clk_sys(i_clk_sys), .i_dma_crc_ready(o_dma_crc_ready),
    .o_chan_enable(i_chan_enable), .o_dma_crc_valid(i_dma_crc_valid),
    .o_dma_crc_data(i_dma_crc_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // msb-first register, low byte of the word folded first
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] w,
      input int nb, input logic p32);
    for (int i = 0; i < nb; i++) begin
      c ^= p32 ? {w[8*i+:8], 24'h0} : {16'h0, w[8*i+:8], 8'h0};
      for (int k = 0; k < 8; k++) begin
        if (p32) c = c[31] ? (c << 1) ^ DCQ_GEN_CRC32 : c << 1;
        else c = {16'h0, c[15] ? (c[15:0] << 1) ^ DCQ_GEN_CRC16 : c[15:0] << 1};
      end
    end
    return c;
  endfunction : crc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_htrans <= DCQ_HTRANS_NONSEQ;
    i_hwrite <= wr;
    i_haddr <= {22'h0, idx, 2'b00};
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    v = o_hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(v, exp);
  endtask : rdc
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    error_cnt++;
    end_sim();
  end
  initial begin
    i_srst = 1'b1;
    i_hsel = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0;
    i_chan_pending = 6'h00;
    i_cpu_debug_halted = 1'b0;
    rnd = 32'he7f5;
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(posedge i_clk_sys);
    rdc(DCQ_IDX_SERVICE, 32'h15);
    for (int i = 0; i < 4; i++) begin
      e = {26'h0, 2'(i), 2'(i ^ 1), 2'(i ^ 2)};
      wr(DCQ_IDX_SERVICE, e);
      rdc(DCQ_IDX_SERVICE, e);
      chk({26'h0, o_transfer_service_level, o_fetch_service_level,
        o_writeback_service_level}, e);
    end
    wr(DCQ_IDX_DEBUG, 32'h1);
    i_cpu_debug_halted <= 1'b1;
    rdc(DCQ_IDX_DEBUG, 32'h1);
    chk(o_dma_halted, 32'h0);
    wr(DCQ_IDX_CONTROL, 32'h1);
    rdc(DCQ_IDX_DEBUG, 32'h1);
    rdc(DCQ_IDX_SERVICE, 32'h15);
    wr(DCQ_IDX_DEBUG, 32'h0);
    rdc(DCQ_IDX_DEBUG, 32'h0);
    chk(o_dma_halted, 32'h1);
    i_cpu_debug_halted <= 1'b0;
    wr(DCQ_IDX_TRIGGER, 32'h3f);
    rdc(DCQ_IDX_TRIGGER, 32'h3f);
    i_chan_pending <= 6'h01;
    rdc(DCQ_IDX_TRIGGER, 32'h3e);
    i_chan_pending <= 6'h00;
    chk(o_per_channel_trigger_bit, 32'h3e);
    wr(DCQ_IDX_CONTROL, 32'h6);
    rdc(DCQ_IDX_CONTROL, 32'h6);
    chk(o_dma_enable, 32'h1);
    // two input words back to back: the second waits for the engine
    rnd = lfsr(rnd);
    wr(DCQ_IDX_RESULT, 32'h0);
    wr(DCQ_IDX_SETUP, 32'h0106);
    wr(DCQ_IDX_INPUT, rnd);
    wr(DCQ_IDX_INPUT, ~rnd);
    rdc(DCQ_IDX_STATUS, 32'h1);
    wr(DCQ_IDX_SETUP, 32'h2006);
    rdc(DCQ_IDX_SETUP, 32'h0106);
    wr(DCQ_IDX_STATUS, 32'h0);
    rdc(DCQ_IDX_STATUS, 32'h1);
    wr(DCQ_IDX_STATUS, 32'h1);
    rdc(DCQ_IDX_STATUS, 32'h0);
    e = {<<{crc(crc(32'h0, rnd, 4, 1'b1), ~rnd, 4, 1'b1)}};
    rdc(DCQ_IDX_RESULT, e);
    // width code 3 is served as a full word
    for (int w = 0; w < 4; w++) begin
      rnd = lfsr(rnd);
      wr(DCQ_IDX_RESULT, 32'h0);
      wr(DCQ_IDX_SETUP, 32'h0100 | w);
      wr(DCQ_IDX_INPUT, rnd);
      wr(DCQ_IDX_STATUS, 32'h1);
      rdc(DCQ_IDX_STATUS, 32'h0);
      rdc(DCQ_IDX_RESULT, crc(32'h0, rnd, (w == 3) ? 4 : 1 << w, 1'b0));
    end
    wr(DCQ_IDX_RESULT, 32'h0);
    wr(DCQ_IDX_SETUP, 32'h0100);
    wr(DCQ_IDX_INPUT, rnd & 32'hffffff00);
    wr(DCQ_IDX_STATUS, 32'h1);
    rdc(DCQ_IDX_STATUS, 32'h2);
    wr(DCQ_IDX_SETUP, 32'h0100);
    rdc(DCQ_IDX_STATUS, 32'h0);
    rnd = lfsr(rnd);
    wr(DCQ_IDX_RESULT, 32'h0);
    wr(DCQ_IDX_SETUP, 32'h2006);
    dcq_chan_feed_inst.set_en(0, 1'b1);
    dcq_chan_feed_inst.push(rnd, 2);
    rdc(DCQ_IDX_STATUS, 32'h1);
    wr(DCQ_IDX_STATUS, 32'h1);
    chk(o_hresp, 32'h0);
    rdc(DCQ_IDX_STATUS, 32'h1);
    dcq_chan_feed_inst.push(~rnd, 0);
    dcq_chan_feed_inst.set_en(0, 1'b0);
    rdc(DCQ_IDX_STATUS, 32'h0);
    e = {<<{crc(crc(32'h0, rnd, 4, 1'b1), ~rnd, 4, 1'b1)}};
    rdc(DCQ_IDX_RESULT, e);
    end_sim();
  end
endmodule : tb
